// file: dlwf_defines.svh
// Constants for the display list writer and font lookup block
`ifndef DLWF_DEFINES_SVH
`define DLWF_DEFINES_SVH
// Register byte offsets
`define DLWF_OFS_CTRL       8'h00
`define DLWF_OFS_STATUS     8'h04
`define DLWF_OFS_DL_PTR     8'h08
`define DLWF_OFS_CMD_WP     8'h0C
`define DLWF_OFS_CMD_RP     8'h10
`define DLWF_OFS_CMD_DATA   8'h14
`define DLWF_OFS_FONT_SEL   8'h18
`define DLWF_OFS_CODEPOINT  8'h1C
`define DLWF_OFS_FONT_BASE  8'h20
`define DLWF_OFS_ROM_ROOT   8'h24
`define DLWF_OFS_RES_ADDR   8'h28
`define DLWF_OFS_RES_WIDTH  8'h2C
`define DLWF_OFS_LOOKUP     8'h30
// Command encodings
`define DLWF_CMD_PREFIX     8'hFF
`define DLWF_CMD_NEWLIST    32'hFFFFFF00
`define DLWF_CMD_KEYBOARD   32'hFFFFFF0E
// Sizes
`define DLWF_CMD_AW         10
`define DLWF_DL_AW          11
`define DLWF_LEGACY_SIZE    32'h00000094
`define DLWF_LEGACY_FMT     32'h00000080
`define DLWF_LEGACY_STRIDE  32'h00000084
`define DLWF_LEGACY_HEIGHT  32'h0000008C
`define DLWF_LEGACY_GPTR    32'h00000090
`define DLWF_ROM_FIRST      5'h10
`define DLWF_ROM_COUNT      6'h13
`define DLWF_XF_SIG         32'h0100AAFF
`define DLWF_XF_FMT         32'h00000008
`define DLWF_XF_STRIDE      32'h00000010
`define DLWF_XF_HEIGHT      32'h00000014
`define DLWF_XF_START       32'h00000020
`define DLWF_XF_COUNT       32'h00000024
`define DLWF_XF_TABLE       32'h00000028
`define DLWF_FLASH_BASE     32'h00800000
// Excluded formats: text mode, small text, bar graph, paletted
`define DLWF_FMT_TEXT_MODE  32'h0000000A
`define DLWF_FMT_SMALL_TEXT 32'h00000009
`define DLWF_FMT_BAR_GRAPH  32'h0000000B
`define DLWF_FMT_PALETTED   32'h00000005
`endif

// file: dlwf_pkg.sv
// Types shared by the display list writer and font lookup block
package dlwf_pkg;
	// Font lookup sequencer states
	typedef enum logic [3:0] {
		DLWF_F_IDLE, DLWF_F_SIG, DLWF_F_FMT, DLWF_F_STRIDE, DLWF_F_HEIGHT,
		DLWF_F_START, DLWF_F_COUNT, DLWF_F_GOFS, DLWF_F_WOFS, DLWF_F_WIDTH
	} dlwf_fstate_t;
endpackage

// file: dlwf_ram.sv
// Simple single-port word memory with registered read data
module dlwf_ram #(
	parameter int AW = 10
) (
	// Clock
	input  wire logic          clk_sys,
	// Access port
	input  wire logic          we,
	input  wire logic [AW-1:0] addr,
	input  wire logic [31:0]   wdata,
	output logic      [31:0]   rdata
);
	// Storage array
	logic [31:0] mem [0:(1<<AW)-1];

	// Write and registered read
	always_ff @(posedge clk_sys)
	begin
		if (we)
		begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end
endmodule

// file: dlwf_top.sv
// Display list writer and font metrics lookup engine
// Functional notes
// - Generated words go to write pointer slot
// - Advance write pointer after each stored word
// - New-list command clears write pointer
// - Plain list commands copied unchanged
// - Raise empty event after last command
// - Font handles range 0 to 31
// - Legacy block 148 bytes, width table first
// - Legacy words from 128, pointer at 144
// - Format excludes text, bar, paletted formats
// - Built-in array of 19 blocks in ROM
// - Built-in block at base plus 148*(n-16)
// - Extended block starts with signature, size
// - Extended header words at offsets 8-36
// - Count multiple of 128, tables from 40
// - Glyph offsets per 128 codes, from start
// - Width offsets relative to block base
// - Flash glyph sum divided by 32
// - Keyboard widget: single-byte characters only
// - Host writes FIFO, engine advances read pointer
//
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`include "dlwf_defines.svh"
module dlwf_top
	import dlwf_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        reset,
	// AXI4-Lite write address
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Graphics memory read port (metrics blocks)
	output logic [31:0]      gmem_addr,
	output logic             gmem_req,
	input  wire logic [31:0] gmem_rdata,
	input  wire logic        gmem_ack,
	// Completion event
	output logic             command_empty_interrupt
);
	// ==================================================
	// State record
	// ==================================================
	typedef struct packed {
		logic                     aw_got;     // Write address held
		logic                     w_got;      // Write data held
		logic [7:0]               awaddr;     // Held write address
		logic [31:0]              wdata;      // Held write data
		logic                     bvalid;     // Write response pending
		logic                     rvalid;     // Read data pending
		logic [31:0]              rdata;      // Read data
		logic [`DLWF_CMD_AW-1:0]  cmd_wp;     // FIFO write pointer (words)
		logic [`DLWF_CMD_AW-1:0]  cmd_rp;     // FIFO read pointer (words)
		logic                     fetch;      // FIFO word being read
		logic                     skip;       // Next word is keys argument
		logic [`DLWF_DL_AW-1:0]   dl_ptr;     // Display list write pointer
		logic                     dl_we;      // Display list write strobe
		logic [31:0]              dl_word;    // Word to store
		logic                     empty_ev;   // Completion pulse
		logic                     empty_sticky; // Completion seen
		logic                     keys_ascii; // Keyboard widget single-byte mode
		dlwf_fstate_t             fst;        // Lookup state
		logic [4:0]               font_sel;   // Font handle
		logic [31:0]              codept;     // Code point
		logic [31:0]              font_base;  // User metrics base
		logic [31:0]              rom_root;   // Built-in array base
		logic [31:0]              blk;        // Resolved block base
		logic [31:0]              stride;     // Line stride
		logic [31:0]              height;     // Bitmap height
		logic [31:0]              gstart;     // Glyph data start
		logic [31:0]              gofs;       // Group glyph offset
		logic                     ext;        // Extended block
		logic [31:0]              res_addr;   // Glyph address result
		logic [7:0]               res_width;  // Width result
		logic                     fmt_err;    // Bad format or block
		logic                     gmem_req;   // Memory request
		logic [31:0]              gmem_addr;  // Memory address
	} dlwf_state_t;

	dlwf_state_t s_q;   // Registered state
	dlwf_state_t s_d;   // Next state

	// ==================================================
	// Memories
	// ==================================================
	logic                     cmd_we;     // Host writes FIFO word
	logic [`DLWF_CMD_AW-1:0]  cmd_addr;   // FIFO address
	logic [31:0]              cmd_rdata;  // FIFO read word
	logic [31:0]              dl_rdata;   // Unused list readback

	// Host writes land at the write pointer, engine reads at the read pointer
	assign cmd_we   = s_q.aw_got && s_q.w_got && !s_q.bvalid
		&& (s_q.awaddr == `DLWF_OFS_CMD_DATA);
	assign cmd_addr = cmd_we ? s_q.cmd_wp : s_q.cmd_rp;

	// Command FIFO storage
	dlwf_ram #(.AW(`DLWF_CMD_AW)) u_cmd_fifo (
		.clk_sys (clk_sys),
		.we      (cmd_we),
		.addr    (cmd_addr),
		.wdata   (s_q.wdata),
		.rdata   (cmd_rdata)
	);

	// Display list memory, written at the write pointer
	dlwf_ram #(.AW(`DLWF_DL_AW)) u_display_list_memory (
		.clk_sys (clk_sys),
		.we      (s_q.dl_we),
		.addr    (s_q.dl_ptr),
		.wdata   (s_q.dl_word),
		.rdata   (dl_rdata)
	);

	// ==================================================
	// Next-state logic
	// ==================================================
	logic        busy;      // Engine has outstanding work
	logic [31:0] grp;       // Code point group index
	logic [31:0] rom_idx;   // Built-in font index

	always_comb
	begin
		s_d = s_q;
		busy = (s_q.cmd_rp != s_q.cmd_wp) || s_q.fetch;
		grp = s_q.codept >> 7;
		rom_idx = {27'h0, s_q.font_sel} - {27'h0, `DLWF_ROM_FIRST};
		s_d.dl_we = 1'b0;
		s_d.empty_ev = 1'b0;
		// Pointer advances once per stored word only
		if (s_q.dl_we)
		begin
			s_d.dl_ptr = s_q.dl_ptr + 1'b1;
		end
		// Bus write capture
		if (s_axi_awvalid && !s_q.aw_got)
		begin
			s_d.aw_got = 1'b1;
			s_d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_q.w_got)
		begin
			s_d.w_got = 1'b1;
			s_d.wdata = s_axi_wdata;
		end
		// Write commit after both halves arrive
		if (s_q.aw_got && s_q.w_got && !s_q.bvalid)
		begin
			s_d.bvalid = 1'b1;
			case (s_q.awaddr)
				`DLWF_OFS_CMD_DATA: s_d.cmd_wp = s_q.cmd_wp + 1'b1;
				`DLWF_OFS_FONT_SEL: s_d.font_sel = s_q.wdata[4:0];
				`DLWF_OFS_CODEPOINT:
				begin
					// Keyboard mode keeps only one byte
					s_d.codept = s_q.keys_ascii ? {24'h0, s_q.wdata[7:0]} : s_q.wdata;
				end
				`DLWF_OFS_FONT_BASE: s_d.font_base = s_q.wdata;
				`DLWF_OFS_ROM_ROOT: s_d.rom_root = s_q.wdata;
				`DLWF_OFS_CTRL: s_d.keys_ascii = s_q.wdata[0];
				`DLWF_OFS_LOOKUP:
				begin
					// Built-in fonts resolve from the ROM array
					if (s_q.fst == DLWF_F_IDLE)
					begin
						s_d.fmt_err = 1'b0;
						if (s_q.font_sel >= `DLWF_ROM_FIRST
							&& rom_idx < {26'h0, `DLWF_ROM_COUNT})
						begin
							s_d.blk = s_q.rom_root + rom_idx * `DLWF_LEGACY_SIZE;
						end
						else
						begin
							s_d.blk = s_q.font_base;
						end
						s_d.fst = DLWF_F_SIG;
						s_d.gmem_req = 1'b1;
						s_d.gmem_addr = s_d.blk;
					end
				end
				default: ;
			endcase
			s_d.aw_got = 1'b0;
			s_d.w_got = 1'b0;
		end
		if (s_q.bvalid && s_axi_bready)
		begin
			s_d.bvalid = 1'b0;
		end
		// Bus read
		if (s_axi_arvalid && !s_q.rvalid)
		begin
			s_d.rvalid = 1'b1;
			case (s_axi_araddr)
				`DLWF_OFS_STATUS: s_d.rdata = {28'h0, s_q.fmt_err, s_q.fst != DLWF_F_IDLE,
					s_q.empty_sticky, busy};
				`DLWF_OFS_CTRL: s_d.rdata = {31'h0, s_q.keys_ascii};
				`DLWF_OFS_DL_PTR: s_d.rdata = {21'h0, s_q.dl_ptr};
				`DLWF_OFS_CMD_WP: s_d.rdata = {22'h0, s_q.cmd_wp};
				`DLWF_OFS_CMD_RP: s_d.rdata = {22'h0, s_q.cmd_rp};
				`DLWF_OFS_FONT_SEL: s_d.rdata = {27'h0, s_q.font_sel};
				`DLWF_OFS_CODEPOINT: s_d.rdata = s_q.codept;
				`DLWF_OFS_FONT_BASE: s_d.rdata = s_q.font_base;
				`DLWF_OFS_ROM_ROOT: s_d.rdata = s_q.rom_root;
				`DLWF_OFS_RES_ADDR: s_d.rdata = s_q.res_addr;
				`DLWF_OFS_RES_WIDTH: s_d.rdata = {24'h0, s_q.res_width};
				default: s_d.rdata = 32'h0;
			endcase
			// Reading status clears the completion flag unless it re-fires
			if (s_axi_araddr == `DLWF_OFS_STATUS && !s_q.empty_ev)
			begin
				s_d.empty_sticky = 1'b0;
			end
		end
		if (s_q.rvalid && s_axi_rready)
		begin
			s_d.rvalid = 1'b0;
		end
		// Command engine: read address presented one cycle, data next
		if (s_q.fetch)
		begin
			s_d.fetch = 1'b0;
			s_d.cmd_rp = s_q.cmd_rp + 1'b1;
			if (s_q.skip)
			begin
				// Argument word of the keyboard widget is consumed
				s_d.skip = 1'b0;
			end
			else if (cmd_rdata == `DLWF_CMD_NEWLIST)
			begin
				s_d.dl_ptr = '0;
			end
			else if (cmd_rdata == `DLWF_CMD_KEYBOARD)
			begin
				s_d.skip = 1'b1;
				s_d.keys_ascii = 1'b1;
			end
			else if (cmd_rdata[31:24] != `DLWF_CMD_PREFIX)
			begin
				s_d.dl_we = 1'b1;
				s_d.dl_word = cmd_rdata;
			end
			// Last outstanding word done
			if (s_q.cmd_rp + 1'b1 == s_q.cmd_wp)
			begin
				s_d.empty_ev = 1'b1;
				s_d.empty_sticky = 1'b1;
			end
		end
		else if (s_q.cmd_rp != s_q.cmd_wp && !cmd_we && !s_q.dl_we)
		begin
			s_d.fetch = 1'b1;
		end
		// Metrics lookup sequencer
		if (s_q.gmem_req && gmem_ack)
		begin
			s_d.gmem_req = 1'b0;
			case (s_q.fst)
				DLWF_F_SIG:
				begin
					// Signature picks the block layout
					s_d.ext = (gmem_rdata == `DLWF_XF_SIG);
					s_d.fst = DLWF_F_FMT;
					s_d.gmem_addr = s_q.blk + ((gmem_rdata == `DLWF_XF_SIG)
						? `DLWF_XF_FMT : `DLWF_LEGACY_FMT);
				end
				DLWF_F_FMT:
				begin
					if (gmem_rdata == `DLWF_FMT_TEXT_MODE || gmem_rdata == `DLWF_FMT_SMALL_TEXT
						|| gmem_rdata == `DLWF_FMT_BAR_GRAPH || gmem_rdata == `DLWF_FMT_PALETTED)
					begin
						s_d.fmt_err = 1'b1;
					end
					s_d.fst = DLWF_F_STRIDE;
					s_d.gmem_addr = s_q.blk + (s_q.ext ? `DLWF_XF_STRIDE : `DLWF_LEGACY_STRIDE);
				end
				DLWF_F_STRIDE:
				begin
					s_d.stride = gmem_rdata;
					s_d.fst = DLWF_F_HEIGHT;
					s_d.gmem_addr = s_q.blk + (s_q.ext ? `DLWF_XF_HEIGHT : `DLWF_LEGACY_HEIGHT);
				end
				DLWF_F_HEIGHT:
				begin
					s_d.height = gmem_rdata;
					s_d.fst = DLWF_F_START;
					s_d.gmem_addr = s_q.blk + (s_q.ext ? `DLWF_XF_START : `DLWF_LEGACY_GPTR);
				end
				DLWF_F_START:
				begin
					s_d.gstart = gmem_rdata;
					if (s_q.ext)
					begin
						s_d.fst = DLWF_F_COUNT;
						s_d.gmem_addr = s_q.blk + `DLWF_XF_COUNT;
					end
					else
					begin
						// Legacy: contiguous glyphs, width table at block start
						s_d.res_addr = gmem_rdata
							+ s_q.stride * s_q.height * {25'h0, s_q.codept[6:0]};
						s_d.fst = DLWF_F_WIDTH;
						s_d.gmem_addr = s_q.blk + {25'h0, s_q.codept[6:0]};
					end
				end
				DLWF_F_COUNT:
				begin
					// Count must be a nonzero multiple of 128 covering the code point
					if (gmem_rdata[6:0] != 7'h0 || grp >= (gmem_rdata >> 7))
					begin
						s_d.fmt_err = 1'b1;
						s_d.fst = DLWF_F_IDLE;
					end
					else
					begin
						s_d.fst = DLWF_F_GOFS;
						s_d.gmem_addr = s_q.blk + `DLWF_XF_TABLE + (grp << 2);
						s_d.height = s_q.height;
						s_d.res_width = 8'h0;
						s_d.stride = s_q.stride;
						s_d.gofs = gmem_rdata;
					end
				end
				DLWF_F_GOFS:
				begin
					// Width table follows glyph table; gofs held the count here
					s_d.gmem_addr = s_q.blk + `DLWF_XF_TABLE + ((s_q.gofs >> 7) << 2)
						+ (grp << 2);
					s_d.gofs = gmem_rdata + s_q.stride * s_q.height * {25'h0, s_q.codept[6:0]};
					s_d.fst = DLWF_F_WOFS;
				end
				DLWF_F_WOFS:
				begin
					// Flash data addresses count 32-byte units
					s_d.res_addr = s_q.gstart + ((s_q.gstart >= `DLWF_FLASH_BASE)
						? (s_q.gofs >> 5) : s_q.gofs);
					s_d.gmem_addr = s_q.blk + gmem_rdata + {25'h0, s_q.codept[6:0]};
					s_d.fst = DLWF_F_WIDTH;
				end
				DLWF_F_WIDTH:
				begin
					// Byte lane select within the fetched word
					s_d.res_width = gmem_rdata[{s_q.gmem_addr[1:0], 3'b000} +: 8];
					s_d.fst = DLWF_F_IDLE;
				end
				default: s_d.fst = DLWF_F_IDLE;
			endcase
			if (s_d.fst != DLWF_F_IDLE)
			begin
				s_d.gmem_req = 1'b1;
			end
		end
	end

	// ==================================================
	// State register
	// ==================================================
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			s_q <= '0;
			s_q.fst <= DLWF_F_IDLE;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// ==================================================
	// Outputs
	// ==================================================
	assign s_axi_awready = !s_q.aw_got;
	assign s_axi_wready  = !s_q.w_got;
	assign s_axi_bvalid  = s_q.bvalid;
	assign s_axi_bresp   = 2'h0;
	assign s_axi_arready = !s_q.rvalid;
	assign s_axi_rvalid  = s_q.rvalid;
	assign s_axi_rdata   = s_q.rdata;
	assign s_axi_rresp   = 2'h0;
	assign gmem_req      = s_q.gmem_req;
	assign gmem_addr     = {s_q.gmem_addr[31:2], 2'b00};
	assign command_empty_interrupt = s_q.empty_ev;
endmodule

// file: dlwf_chk_sva.sv
// Port-level assertion checker for the display list writer and font lookup
module dlwf_chk
	import dlwf_pkg::*;
(
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        reset,
	// Register bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Metrics fetch and event
	input wire logic [31:0] gmem_addr,
	input wire logic        gmem_req,
	input wire logic        gmem_ack,
	input wire logic        command_empty_interrupt
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// Timing base
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	// ==========
	// Properties
	property p_irq_pulse;
		command_empty_interrupt |=> !command_empty_interrupt;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("empty event wider than one cycle");
	property p_fetch_hold;
		gmem_req && !gmem_ack |=> gmem_req && $stable(gmem_addr);
	endproperty
	a_fetch_hold: assert property (p_fetch_hold) else $error("metrics fetch dropped early");
	// A lookup only starts from an accepted start write
	property p_fetch_start;
		$rose(gmem_req) |-> s_axi_bvalid;
	endproperty
	a_fetch_start: assert property (p_fetch_start) else $error("metrics fetch began unasked");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer withdrawn");
	property p_b_okay;
		s_axi_bvalid |-> s_axi_bresp == 2'b00;
	endproperty
	a_b_okay: assert property (p_b_okay) else $error("write answer not okay");
	property p_b_after;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
	endproperty
	a_b_after: assert property (p_b_after) else $error("write answer late");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer changed");
	property p_r_after;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rresp == 2'b00;
	endproperty
	a_r_after: assert property (p_r_after) else $error("read answer missing");
	// Main scenarios reached
	c_irq: cover property (command_empty_interrupt);
	c_fetch: cover property (gmem_req && gmem_ack);
	c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind dlwf_top dlwf_chk u_chk (.clk_sys, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .gmem_addr, .gmem_req, .gmem_ack,
	.command_empty_interrupt);

// file: dlwf_gmem_model.sv
// Graphics memory model that answers metrics block fetches
module dlwf_gmem_model
	import dlwf_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        reset,
	// Fetch request
	input  wire logic [31:0] gmem_addr,
	input  wire logic        gmem_req,
	input  wire logic        slow,
	// Fetch answer
	output logic      [31:0] gmem_rdata,
	output logic             gmem_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// Storage: each byte holds its own low address bits
	logic [31:0] mem [256];
	logic [3:0]  wait_q;    // Cycles the request has waited
	initial
	begin
		for (int i = 0; i < 256; i++)
			mem[i] = {8'(4 * i + 3), 8'(4 * i + 2), 8'(4 * i + 1), 8'(4 * i)};
	end
	// ==========
	// Answer logic; data inverts between answers so stale reads show
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			gmem_ack   <= 1'b0;
			gmem_rdata <= 32'h00000000;
			wait_q     <= 4'h0;
		end
		else if (gmem_req && !gmem_ack && wait_q >= (slow ? 4'h5 : 4'h0))
		begin
			gmem_ack   <= 1'b1;
			gmem_rdata <= mem[gmem_addr[9:2]];
			wait_q     <= 4'h0;
		end
		else
		begin
			gmem_ack   <= 1'b0;
			gmem_rdata <= ~gmem_rdata;
			wait_q     <= gmem_req ? wait_q + 4'h1 : 4'h0;
		end
	end
endmodule

// file: dlwf_top_test.sv
// Self-checking testbench for the display list writer and font lookup
`include "dlwf_defines.svh"
module dlwf_top_test
	import dlwf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// Bench signals
	logic        clk_sys, reset, slow, gmem_req, gmem_ack, command_empty_interrupt;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, gmem_addr, gmem_rdata, rd_val, ra, rw;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [3:0]  s_axi_wstrb;
	int          err_total, checks, irq_n, cyc;
	dlwf_top dut (.*);
	dlwf_gmem_model gm (.*);
	// ==========
	// Clock, watchdog and event counter
	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys)
	begin
		cyc++;
		if (command_empty_interrupt === 1'b1)
			irq_n++;
		if (cyc == 20000)
		begin
			err_total++;
			tally_and_finish();
		end
	end
	// ==========
	// Shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge clk_sys);
			if (!aw_ok && s_axi_awready === 1'b1)
			begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_ok && s_axi_wready === 1'b1)
			begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (!(aw_ok && w_ok));
		do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic axi_rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
		rd_val = s_axi_rdata;
		s_axi_rready <= 1'b0;
		@(posedge clk_sys);
	endtask
	// Host polls read against write pointer, then may read the list pointer
	task automatic wait_fifo();
		logic [31:0] wp;
		do
		begin
			axi_rd(`DLWF_OFS_CMD_WP);
			wp = rd_val;
			axi_rd(`DLWF_OFS_CMD_RP);
		end
		while (rd_val !== wp);
		axi_rd(`DLWF_OFS_DL_PTR);
	endtask
	task automatic lookup(input logic [4:0] h, input logic [31:0] cp, input logic [31:0] b);
		axi_wr(`DLWF_OFS_FONT_SEL, {27'h0, h});
		axi_wr(`DLWF_OFS_CODEPOINT, cp);
		axi_wr(`DLWF_OFS_FONT_BASE, b);
		axi_wr(`DLWF_OFS_ROM_ROOT, 32'h00000200);
		axi_wr(`DLWF_OFS_LOOKUP, 32'h00000001);
		do axi_rd(`DLWF_OFS_STATUS); while (rd_val[2] !== 1'b0);
		axi_rd(`DLWF_OFS_RES_ADDR);
		ra = rd_val;
		axi_rd(`DLWF_OFS_RES_WIDTH);
		rw = rd_val;
	endtask
	// ==========
	// Scenarios
	task automatic t_list();
		logic [31:0] plain [3] = '{32'h02FF6464, 32'h26000007, 32'h00000000};
		axi_wr(`DLWF_OFS_CMD_DATA, `DLWF_CMD_NEWLIST);
		foreach (plain[i])
			axi_wr(`DLWF_OFS_CMD_DATA, plain[i]);
		wait_fifo();
		chk(rd_val, 32'h00000003);
		foreach (plain[i])
			chk(dut.u_display_list_memory.mem[i], plain[i]);
		axi_rd(`DLWF_OFS_STATUS);
		chk({30'h0, rd_val[1:0]}, 32'h00000002);
		axi_rd(`DLWF_OFS_STATUS);
		chk({31'h0, rd_val[1]}, 32'h00000000);
		chk({31'h0, irq_n != 0}, 32'h00000001);
		axi_wr(`DLWF_OFS_CMD_DATA, `DLWF_CMD_KEYBOARD);
		axi_wr(`DLWF_OFS_CMD_DATA, 32'h00000041);
		wait_fifo();
		chk(rd_val, 32'h00000003);
		axi_rd(`DLWF_OFS_CTRL);
		chk({31'h0, rd_val[0]}, 32'h00000001);
		axi_wr(`DLWF_OFS_CODEPOINT, 32'h00000141);
		axi_rd(`DLWF_OFS_CODEPOINT);
		chk(rd_val, 32'h00000041);
		// Leave single-byte mode so later lookups see full code points
		axi_wr(`DLWF_OFS_CTRL, 32'h00000000);
		axi_wr(`DLWF_OFS_CMD_DATA, 32'hFFFFFF0C);
		axi_wr(`DLWF_OFS_CMD_DATA, plain[0]);
		axi_wr(`DLWF_OFS_CMD_DATA, plain[1]);
		wait_fifo();
		chk(rd_val, 32'h00000005);
		chk(dut.u_display_list_memory.mem[3], plain[0]);
		chk(dut.u_display_list_memory.mem[4], plain[1]);
		axi_wr(`DLWF_OFS_CMD_DATA, `DLWF_CMD_NEWLIST);
		wait_fifo();
		chk(rd_val, 32'h00000000);
	endtask
	// Width bytes equal their address low bits in the memory model
	task automatic t_legacy();
		logic [4:0]  h [3] = '{5'h03, 5'h11, 5'h1F};
		logic [31:0] c [3] = '{32'h41, 32'h67, 32'h7F};
		logic [31:0] w [3] = '{32'h41, 32'hFB, 32'h2B};
		// Small stride, height and glyph pointer in the user block at zero
		gm.mem[8'h21] = 32'h00000002;
		gm.mem[8'h23] = 32'h00000003;
		gm.mem[8'h24] = 32'h00001000;
		for (int i = 0; i < 3; i++)
		begin
			lookup(h[i], c[i], 32'h00000000);
			chk(rw, w[i]);
			if (i == 0)
				chk(ra, 32'h00001186);
		end
		gm.mem[8'h20] = `DLWF_FMT_PALETTED;
		lookup(5'h03, 32'h00000041, 32'h00000000);
		axi_rd(`DLWF_OFS_STATUS);
		chk({31'h0, rd_val[3]}, 32'h00000001);
	endtask
	task automatic t_ext();
		logic [31:0] blk [14] = '{32'h0100AAFF, 32'h138, 32'h1, 32'h0, 32'h4, 32'h8, 32'h0,
			32'h0, 32'h1000, 32'h100, 32'h0, 32'h400, 32'h38, 32'hB8};
		foreach (blk[i])
			gm.mem[8'h40 + i] = blk[i];
		lookup(5'h05, 32'd130, 32'h00000100);
		chk(ra, 32'h00001440);
		chk(rw, 32'h000000BA);
		axi_rd(`DLWF_OFS_STATUS);
		chk({31'h0, rd_val[3]}, 32'h00000000);
		lookup(5'h05, 32'd5, 32'h00000100);
		chk(ra, 32'h000010A0);
		chk(rw, 32'h0000003D);
	endtask
	task automatic t_flash();
		slow <= 1'b1;
		gm.mem[8'h48] = `DLWF_FLASH_BASE;
		lookup(5'h05, 32'd130, 32'h00000100);
		chk(ra, 32'h00800022);
		lookup(5'h05, 32'd256, 32'h00000100);
		axi_rd(`DLWF_OFS_STATUS);
		chk({31'h0, rd_val[3]}, 32'h00000001);
	endtask
	// ==========
	// Verdict
	task automatic tally_and_finish();
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, slow} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		reset = 1'b1;
		repeat (6) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		t_list();
		t_legacy();
		t_ext();
		t_flash();
		tally_and_finish();
	end
endmodule
